//--- hdl/dbs_pkg.sv
// Constants for the dual byte buffer with boundary scan
package dbs_pkg;
    // Datapath and register widths
    localparam int BYTE_W  = 9;
    localparam int IR_W    = 8;
    localparam int CHAIN_W = 42;

    // Instruction codes, shifted LSB first
    localparam logic [7:0] IR_EXTEST = 8'h00;
    localparam logic [7:0] IR_CLAMP  = 8'h82;
    localparam logic [7:0] IR_HIGHZ  = 8'h03;
    localparam logic [7:0] IR_BYPASS = 8'hFF;
    // Capture pattern and sample code; value is arbitrary, low bits 01
    localparam logic [7:0] IR_CAPTURE = 8'hA5;
    localparam logic [7:0] IR_SAMPLE  = IR_CAPTURE;
    localparam logic [7:0] IR_RESET   = IR_BYPASS;

    // Boundary chain positions
    localparam int POS_A_PIN1 = 41;
    localparam int POS_A_PIN2 = 40;
    localparam int POS_A_EN   = 39;
    localparam int POS_B_PIN1 = 38;
    localparam int POS_B_PIN2 = 37;
    localparam int POS_B_EN   = 36;
    localparam int POS_A_IN   = 35;
    localparam int POS_B_IN   = 26;
    localparam int POS_A_OUT  = 17;
    localparam int POS_B_OUT  = 8;
    localparam logic [41:0] CHAIN_RESET = 42'h0;

    // Test access port controller states
    typedef enum logic [3:0] {
        DBS_TLR, DBS_RTI, DBS_SEL_DR, DBS_CAP_DR, DBS_SH_DR, DBS_EX1_DR,
        DBS_PA_DR, DBS_EX2_DR, DBS_UPD_DR, DBS_SEL_IR, DBS_CAP_IR,
        DBS_SH_IR, DBS_EX1_IR, DBS_PA_IR, DBS_EX2_IR, DBS_UPD_IR
    } dbs_tap_t;
endpackage

//--- hdl/dbs_top.sv
// Dual 9-bit buffer with boundary-scan test access port
`timescale 1ns/1ps

module dbs_top
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // Test access port
    input  wire logic                      tck,
    input  wire logic                      tms,
    input  wire logic                      tdi,
    output logic                           tdo,
    output logic                           tdo_oe,
    // Byte A
    input  wire logic [dbs_pkg::BYTE_W-1:0] a_byte_inputs,
    input  wire logic                      a_side_enable_pin_one_n,
    input  wire logic                      a_side_enable_pin_two_n,
    output logic [dbs_pkg::BYTE_W-1:0]      a_byte_outputs,
    output logic [dbs_pkg::BYTE_W-1:0]      a_byte_outputs_oe,
    // Byte B
    input  wire logic [dbs_pkg::BYTE_W-1:0] b_byte_inputs,
    input  wire logic                      b_side_enable_pin_one_n,
    input  wire logic                      b_side_enable_pin_two_n,
    output logic [dbs_pkg::BYTE_W-1:0]      b_byte_outputs,
    output logic [dbs_pkg::BYTE_W-1:0]      b_byte_outputs_oe
);
    import dbs_pkg::*;

    function automatic logic sel_chain(input logic [7:0] ir);
        return (ir == IR_EXTEST) || (ir == IR_SAMPLE);
    endfunction
    function automatic logic pins_from_cells(input logic [7:0] ir);
        return (ir == IR_EXTEST) || (ir == IR_CLAMP);
    endfunction

    // scan, byte and enable pins synchronised; stage one read by stage two only
    localparam int SW = 3 + 2 * BYTE_W + 4;
    logic [SW-1:0] meta_q;
    logic [SW-1:0] sync_q;
    logic          tck_d1_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_q   <= '0;
            tck_d1_q <= 1'b0;
        end else begin
            meta_q   <= {tck, tms, tdi, a_byte_inputs, b_byte_inputs,
                         a_side_enable_pin_one_n, a_side_enable_pin_two_n,
                         b_side_enable_pin_one_n, b_side_enable_pin_two_n};
            sync_q   <= meta_q;
            tck_d1_q <= sync_q[SW-1];
        end
    end

    logic               tck_s;
    logic               tms_s;
    logic               tdi_s;
    logic [BYTE_W-1:0]  a_in_s;
    logic [BYTE_W-1:0]  b_in_s;
    logic               a_p1_s, a_p2_s, b_p1_s, b_p2_s;
    logic               tck_rise, tck_fall;
    logic               a_en_sys, b_en_sys;
    assign {tck_s, tms_s, tdi_s, a_in_s, b_in_s,
            a_p1_s, a_p2_s, b_p1_s, b_p2_s} = sync_q;
    // rise of the sampled test clock
    assign tck_rise = tck_s & ~tck_d1_q;
    // fall of the sampled test clock
    assign tck_fall = ~tck_s & tck_d1_q;
    // system enable is NOR of the two low-active pins
    assign a_en_sys = ~(a_p1_s | a_p2_s);
    assign b_en_sys = ~(b_p1_s | b_p2_s);

    // Scan state
    dbs_tap_t             tap_q,   tap_d;
    logic [IR_W-1:0]      ir_sr_q, ir_sr_d;
    logic [IR_W-1:0]      ir_q,    ir_d;
    logic                 byp_q,   byp_d;
    logic [CHAIN_W-1:0]   chain_q, chain_d;
    logic [CHAIN_W-1:0]   upd_q,   upd_d;
    logic                 tdo_d;
    logic                 tdo_oe_d;
    logic [CHAIN_W-1:0]   cap;

    // Parallel capture image of the chain
    always_comb begin
        cap = '0;
        cap[POS_A_PIN1] = a_p1_s;
        cap[POS_A_PIN2] = a_p2_s;
        cap[POS_A_EN]   = a_en_sys;
        cap[POS_B_PIN1] = b_p1_s;
        cap[POS_B_PIN2] = b_p2_s;
        cap[POS_B_EN]   = b_en_sys;
        // data section, bit 0 of each byte at the high position
        for (int i = 0; i < BYTE_W; i++) begin
            cap[POS_A_IN - i]  = a_in_s[i];
            cap[POS_B_IN - i]  = b_in_s[i];
            // output cells observe the system data path
            cap[POS_A_OUT - i] = a_in_s[i];
            cap[POS_B_OUT - i] = b_in_s[i];
        end
    end

    // Controller, shift paths and update latches
    always_comb begin
        tap_d    = tap_q;
        ir_sr_d  = ir_sr_q;
        ir_d     = ir_q;
        byp_d    = byp_q;
        chain_d  = chain_q;
        upd_d    = upd_q;
        tdo_d    = tdo;
        tdo_oe_d = tdo_oe;
        if (tck_rise) begin
            case (tap_q)
                DBS_TLR:    tap_d = tms_s ? DBS_TLR    : DBS_RTI;
                DBS_RTI:    tap_d = tms_s ? DBS_SEL_DR : DBS_RTI;
                DBS_SEL_DR: tap_d = tms_s ? DBS_SEL_IR : DBS_CAP_DR;
                DBS_CAP_DR: tap_d = tms_s ? DBS_EX1_DR : DBS_SH_DR;
                DBS_SH_DR:  tap_d = tms_s ? DBS_EX1_DR : DBS_SH_DR;
                DBS_EX1_DR: tap_d = tms_s ? DBS_UPD_DR : DBS_PA_DR;
                DBS_PA_DR:  tap_d = tms_s ? DBS_EX2_DR : DBS_PA_DR;
                DBS_EX2_DR: tap_d = tms_s ? DBS_UPD_DR : DBS_SH_DR;
                DBS_UPD_DR: tap_d = tms_s ? DBS_SEL_DR : DBS_RTI;
                DBS_SEL_IR: tap_d = tms_s ? DBS_TLR    : DBS_CAP_IR;
                DBS_CAP_IR: tap_d = tms_s ? DBS_EX1_IR : DBS_SH_IR;
                DBS_SH_IR:  tap_d = tms_s ? DBS_EX1_IR : DBS_SH_IR;
                DBS_EX1_IR: tap_d = tms_s ? DBS_UPD_IR : DBS_PA_IR;
                DBS_PA_IR:  tap_d = tms_s ? DBS_EX2_IR : DBS_PA_IR;
                DBS_EX2_IR: tap_d = tms_s ? DBS_UPD_IR : DBS_SH_IR;
                DBS_UPD_IR: tap_d = tms_s ? DBS_SEL_DR : DBS_RTI;
                default:    tap_d = DBS_TLR;
            endcase
            case (tap_q)
                // fixed capture pattern; low bits 01
                DBS_CAP_IR: ir_sr_d = IR_CAPTURE;
                DBS_SH_IR:  ir_sr_d = {tdi_s, ir_sr_q[IR_W-1:1]};
                DBS_CAP_DR: begin
                    byp_d = 1'b0;
                    if (sel_chain(ir_q)) begin
                        chain_d = cap;
                    end
                end
                DBS_SH_DR: begin
                    // every non-chain code shifts through bypass
                    if (sel_chain(ir_q)) begin
                        chain_d = {tdi_s, chain_q[CHAIN_W-1:1]};
                    end else begin
                        byp_d = tdi_s;
                    end
                end
                default: ;
            endcase
        end
        // serial out, updates and reset act on the falling edge
        if (tck_fall) begin
            tdo_oe_d = (tap_q == DBS_SH_DR) || (tap_q == DBS_SH_IR);
            tdo_d = (tap_q == DBS_SH_IR) ? ir_sr_q[0]
                  : (sel_chain(ir_q) ? chain_q[0] : byp_q);
            case (tap_q)
                DBS_TLR:    ir_d = IR_RESET;
                DBS_UPD_IR: ir_d = ir_sr_q;
                DBS_UPD_DR: begin
                    if (sel_chain(ir_q)) begin
                        upd_d = chain_q;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_q   <= DBS_TLR;
            ir_sr_q <= IR_RESET;
            ir_q    <= IR_RESET;
            byp_q   <= 1'b0;
            chain_q <= CHAIN_RESET;
            upd_q   <= CHAIN_RESET;
            tdo     <= 1'b0;
            tdo_oe  <= 1'b0;
        end else begin
            tap_q   <= tap_d;
            ir_sr_q <= ir_sr_d;
            ir_q    <= ir_d;
            byp_q   <= byp_d;
            chain_q <= chain_d;
            upd_q   <= upd_d;
            tdo     <= tdo_d;
            tdo_oe  <= tdo_oe_d;
        end
    end

    // Pin drivers; registered so a test override lands one clk later
    logic              drive_cells, hiz, a_en, b_en;
    logic [BYTE_W-1:0] a_out_d, b_out_d;
    always_comb begin
        drive_cells = pins_from_cells(ir_q);
        hiz         = (ir_q == IR_HIGHZ);
        // control cell one enables, zero floats the byte
        a_en = hiz ? 1'b0 : (drive_cells ? upd_q[POS_A_EN] : a_en_sys);
        b_en = hiz ? 1'b0 : (drive_cells ? upd_q[POS_B_EN] : b_en_sys);
        // output cells override the system value under EXTEST and CLAMP
        for (int i = 0; i < BYTE_W; i++) begin
            a_out_d[i] = drive_cells ? upd_q[POS_A_OUT - i] : a_in_s[i];
            b_out_d[i] = drive_cells ? upd_q[POS_B_OUT - i] : b_in_s[i];
        end
    end

    // uninverted pass; enables float whole byte; bytes apart
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_byte_outputs    <= '0;
            b_byte_outputs    <= '0;
            a_byte_outputs_oe <= '0;
            b_byte_outputs_oe <= '0;
        end else begin
            a_byte_outputs    <= a_out_d;
            b_byte_outputs    <= b_out_d;
            a_byte_outputs_oe <= {BYTE_W{a_en}};
            b_byte_outputs_oe <= {BYTE_W{b_en}};
        end
    end

    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_A_PASS: assert property (
        $past(rst_n) && $past(ir_q) == IR_BYPASS && $past(a_en_sys) |->
        a_byte_outputs == $past(a_in_s) && &a_byte_outputs_oe)
        else $error("A byte not passing its inputs");
    AST_B_FLOAT: assert property (
        $past(ir_q) == IR_SAMPLE && ($past(b_p1_s) || $past(b_p2_s)) |->
        b_byte_outputs_oe == '0)
        else $error("B byte driven with an enable pin high");
    AST_CELL_EN: assert property (
        pins_from_cells(ir_q) && !upd_q[POS_A_EN] |=> a_byte_outputs_oe == '0)
        else $error("A byte driven with control cell zero");
    AST_BYP_ZERO: assert property (
        tck_rise && tap_q == DBS_CAP_DR |=> byp_q == 1'b0)
        else $error("Bypass did not capture zero");
    AST_IR_CAP: assert property (
        tck_rise && tap_q == DBS_CAP_IR |=> ir_sr_q[1:0] == 2'b01)
        else $error("Instruction capture low bits wrong");
    AST_TLR_IR: assert property (
        tck_fall && tap_q == DBS_TLR |=> ir_q == IR_BYPASS)
        else $error("Reset state did not select bypass");
    AST_TDO_FALL: assert property (
        $changed(tdo) || $changed(ir_q) |-> $past(tck_fall))
        else $error("Serial out or instruction moved off falling edge");
    AST_SHIFT_IN: assert property (
        tck_rise && tap_q == DBS_SH_DR && sel_chain(ir_q) |=>
        chain_q[CHAIN_W-1] == $past(tdi_s))
        else $error("Chain did not take serial in");
    AST_TLR_HOLD: assert property (
        tck_rise && tms_s && tap_q == DBS_TLR |=> tap_q == DBS_TLR)
        else $error("Reset state left with mode select high");
    AST_HIGHZ: assert property (
        ir_q == IR_HIGHZ [*2] |-> a_byte_outputs_oe == '0
        && b_byte_outputs_oe == '0)
        else $error("Outputs driven under high-Z code");

    COV_EXTEST: cover property (tap_q == DBS_UPD_DR && ir_q == IR_EXTEST);
    COV_SHIFT_IR: cover property (tap_q == DBS_SH_IR && tdo_oe);
    COV_CLAMP: cover property (ir_q == IR_CLAMP && |b_byte_outputs_oe);
endmodule

//--- test/dbs_jtag_ctrl.sv
// Behavioural test controller that drives the scan port of the buffer
`timescale 1ns/1ps

module dbs_jtag_ctrl (
    // Scan port towards the device
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    // Serial return from the device
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    int oe_miss;

    // Test clock stands low between frames
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
        oe_miss = 0;
    end

    task automatic step(input logic m, input logic d, input logic sh,
                        output logic o);
        tms <= m;
        tdi <= sh ? d : ~tdi;  // Idle data toggles so no stale value helps
        #62.5;
        o = tdo_oe ? tdo : ~tdo;  // Released line reads inverted, never stale
        if (sh && tdo_oe !== 1'h1)
            oe_miss++;
        tck <= 1'h1;
        #62.5;
        tck <= 1'h0;
    endtask

    // five ones reach reset from any state
    task automatic t_reset();
        logic o;
        repeat (5) step(1'h1, 1'h0, 1'h0, o);
        step(1'h0, 1'h0, 1'h0, o);
    endtask

    // capture, shift LSB first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [41:0] din,
                        output logic [41:0] dout);
        logic o;
        dout = 42'h0;
        step(1'h1, 1'h0, 1'h0, o);
        if (ir)
            step(1'h1, 1'h0, 1'h0, o);
        step(1'h0, 1'h0, 1'h0, o);
        step(1'h0, 1'h0, 1'h0, o);
        for (int k = 0; k < n; k++) begin
            step(k == n - 1, din[k], 1'h1, o);
            dout[k] = o;
        end
        step(1'h1, 1'h0, 1'h0, o);
        step(1'h0, 1'h0, 1'h0, o);
    endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for the dual byte buffer with scan access
`timescale 1ns/1ps

module testbench;
    import dbs_pkg::*;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        tck, tms, tdi, tdo, tdo_oe;
    logic [8:0]  a_in = 9'h000;
    logic [8:0]  b_in = 9'h000;
    logic [3:0]  en_n = 4'h0;
    logic [8:0]  a_out, a_oe, b_out, b_oe;
    logic [31:0] seed = 32'h0001_2FF7;
    int          n_errors = 0;
    int          num_checks = 0;

    always #5 clk = ~clk;

    dbs_top dbs_top_i (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .a_byte_inputs(a_in),
        .a_side_enable_pin_one_n(en_n[3]), .a_side_enable_pin_two_n(en_n[2]),
        .a_byte_outputs(a_out), .a_byte_outputs_oe(a_oe),
        .b_byte_inputs(b_in), .b_side_enable_pin_one_n(en_n[1]),
        .b_side_enable_pin_two_n(en_n[0]), .b_byte_outputs(b_out),
        .b_byte_outputs_oe(b_oe));

    dbs_jtag_ctrl dbs_jtag_ctrl_i (.tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe));

    // Fixed-seed xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected chain image from pin levels; outputs observe their inputs
    function automatic logic [41:0] chain_of(logic [8:0] a, logic [8:0] b,
                                             logic [3:0] e);
        logic [41:0] c;
        c = 42'h0;
        c[41:36] = {e[3], e[2], ~(e[3] | e[2]), e[1], e[0], ~(e[1] | e[0])};
        for (int k = 0; k < BYTE_W; k++) begin
            c[POS_A_IN - k] = a[k];
            c[POS_B_IN - k] = b[k];
            c[POS_A_OUT - k] = a[k];
            c[POS_B_OUT - k] = b[k];
        end
        return c;
    endfunction

    task automatic check(input string what, input logic [41:0] exp,
                         input logic [41:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Pins change at a clock edge, then settle through the synchroniser
    task automatic pins(input logic [8:0] a, input logic [8:0] b,
                        input logic [3:0] e);
        @(posedge clk);
        a_in <= a;
        b_in <= b;
        en_n <= e;
        repeat (6) @(posedge clk);
    endtask

    task automatic check_normal();
        logic ae, be;
        ae = ~(en_n[3] | en_n[2]);
        be = ~(en_n[1] | en_n[0]);
        check("a_oe", {9{ae}}, a_oe);
        check("b_oe", {9{be}}, b_oe);
        if (ae)
            check("a_out", a_in, a_out);
        if (be)
            check("b_out", b_in, b_out);
    endtask

    // Outputs under control of the update stages of the chain
    task automatic check_cells(input logic [41:0] c);
        logic [8:0] ea, eb;
        for (int k = 0; k < BYTE_W; k++) begin
            ea[k] = c[POS_A_OUT - k];
            eb[k] = c[POS_B_OUT - k];
        end
        check("cell a_oe", {9{c[POS_A_EN]}}, a_oe);
        check("cell b_oe", {9{c[POS_B_EN]}}, b_oe);
        check("cell a_out", ea, a_out);
        check("cell b_out", eb, b_out);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    initial begin
        logic [41:0] got, p, q;
        logic [31:0] r, r2;
        logic [7:0]  codes[$];
        repeat (11) @(posedge clk);
        check("reset oe", 42'h0, {tdo_oe, a_oe, b_oe});
        @(posedge clk);
        rst_n <= 1'h1;
        dbs_jtag_ctrl_i.t_reset();
        for (int e = 0; e < 16; e++) begin
            r = rnd();
            pins(r[8:0], r[17:9], e[3:0]);
            check_normal();
        end
        $display("test normal done");
        dbs_jtag_ctrl_i.scan(1'h1, 8, {34'h0, IR_SAMPLE}, got);
        check("ir capture", IR_CAPTURE, got[7:0]);
        check("ir low bits", 2'h1, got[1:0]);
        r = rnd();
        pins(r[8:0], r[17:9], r[21:18]);
        r = rnd();
        r2 = rnd();
        p = {r[9:0], r2};
        p[POS_A_EN] = 1'h1;
        p[POS_B_EN] = 1'h0;
        dbs_jtag_ctrl_i.scan(1'h0, 42, p, got);
        check("sample chain", chain_of(a_in, b_in, en_n), got);
        check_normal();
        $display("test sample done");
        dbs_jtag_ctrl_i.scan(1'h1, 8, {34'h0, IR_EXTEST}, got);
        check_cells(p);
        r = rnd();
        pins(r[8:0], r[17:9], r[21:18]);
        check_cells(p);
        q = ~p;
        dbs_jtag_ctrl_i.scan(1'h0, 42, q, got);
        check_cells(q);
        $display("test extest done");
        codes = {IR_CLAMP, IR_HIGHZ, 8'h01, IR_BYPASS};
        foreach (codes[i]) begin
            dbs_jtag_ctrl_i.scan(1'h1, 8, {34'h0, codes[i]}, got);
            r = rnd();
            dbs_jtag_ctrl_i.scan(1'h0, 8, {34'h0, r[7:0]}, got);
            check("bypass", {r[6:0], 1'h0}, got[7:0]);
            if (codes[i] == IR_CLAMP)
                check_cells(q);
            if (codes[i] == IR_HIGHZ)
                check("highz oe", 42'h0, {a_oe, b_oe});
        end
        $display("test bypass done");
        dbs_jtag_ctrl_i.t_reset();
        r = rnd();
        pins(r[8:0], r[17:9], 4'h0);
        check_normal();
        check("tdo_oe idle", 42'h0, tdo_oe);
        check("tdo_oe shift", 42'h0, dbs_jtag_ctrl_i.oe_miss);
        $display("test reset done");
        report_and_stop();
    end
endmodule
